// ### hdl/icdpi_input_cond.sv
// sixteen-input debounce, inversion and double-point pairing with link settings
`include "icdpi_params.svh"

// Summary of operation
// - pairs start only on odd-numbered inputs; even-start pairing writes are rejected
// - a request to the upper input of a formed pair answers with error
// - pair value is two bits: 00 indeterminate, 01 off
// - pair value 10 is on, 11 is error (both contacts active)
// - unswapped: lower input alone gives off, upper alone gives on
// - per-pair swap exchanges the two inputs' roles
// - inverted input reports 1 when inactive and 0 when active
// - inversion is chosen separately for every input
// - indicator outputs follow the physical level, ignoring inversion
// - a change is accepted only after staying stable for the filter time
// - each input has its own filter time in whole milliseconds
// - all filter times reset to fifty milliseconds
// - baud rate selectable 600 to 115200 from the set, 19200 after reset
// - parity none, odd, even, mark or space, even after reset
// - link address 1 to 256, default 1; one or two stop bits, default one
// - packet bit-wait 8 to 256 bit periods, default 8
// - time sync timeout 1 to 65535 seconds, default 300
// - function type code configurable, default 253
module icdpi_input_cond
  import icdpi_pkg::*;
#(
  parameter int MS_CYCLES = `ICDPI_MS_CYCLES,
  parameter int N_IN      = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // physical inputs, asynchronous
  input  wire logic [N_IN-1:0]   rawIn,
  // register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [31:0]       regRdData,
  // per-input request port
  input  wire logic              qryReq,
  input  wire logic [3:0]        qryIdx,
  output icdpi_qry_s             qryRsp,
  // conditioned results
  output logic      [N_IN-1:0]   ledOut,
  output logic      [N_IN-1:0]   stateOut,
  output logic      [N_IN-1:0]   dpairOut,
  output icdpi_link_s            linkCfg,
  output logic                   irq
);

  localparam int NP = N_IN / 2;

  // synchroniser, filter and configuration state
  logic [N_IN-1:0] sync1_reg, sync2_reg;
  logic [N_IN-1:0] flt_reg, flt_next;
  logic [16:0]     cnt_reg [N_IN];
  logic [16:0]     cnt_next [N_IN];
  logic [15:0]     filtMs_reg [N_IN];
  logic [15:0]     filtMs_next [N_IN];
  logic [31:0]     div_reg, div_next;
  logic            msTick_reg, msTick_next;
  logic [NP-1:0]   group_reg, group_next;
  logic [NP-1:0]   swap_reg, swap_next;
  logic [N_IN-1:0] inv_reg, inv_next;
  logic [2:0]      stat_reg, stat_next;
  logic [2:0]      mask_reg, mask_next;
  icdpi_link_s     link_reg, link_next;
  logic [N_IN-1:0] logicLvl;
  logic [N_IN-1:0] dpair;
  logic [N_IN-1:0] led_reg, state_reg, dpair_reg;
  logic [31:0]     rd_reg, rd_next;
  icdpi_qry_s      qry_reg, qry_next;
  logic            irq_reg;
  logic            wrFilt;
  logic [3:0]      wrFiltIdx;
  logic            rejectEv, qErrEv;

  // two flops on every pin before anything looks at it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= rawIn;
      sync2_reg <= sync1_reg;
    end
  end

  // millisecond timebase, one-cycle enable pulse
  always_comb begin
    msTick_next = 1'b0;
    div_next    = div_reg + 32'h1;
    if (div_reg >= 32'(MS_CYCLES - 1)) begin
      div_next    = '0;
      msTick_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_reg    <= '0;
      msTick_reg <= 1'b0;
    end else begin
      div_reg    <= div_next;
      msTick_reg <= msTick_next;
    end
  end

  assign wrFilt    = regWrEn && (regAddr[7:6] == `ICDPI_FILT_PAGE) && (regAddr[1:0] == 2'h0);
  assign wrFiltIdx = regAddr[5:2];

  // per-input debounce; one tick past the filter time, as the first tick may come at once
  for (genvar i = 0; i < N_IN; i++) begin : g_filt
    always_comb begin
      cnt_next[i]    = cnt_reg[i];
      flt_next[i]    = flt_reg[i];
      filtMs_next[i] = filtMs_reg[i];
      if (wrFilt && (wrFiltIdx == 4'(i))) begin
        filtMs_next[i] = regWrData[15:0];
      end
      if (sync2_reg[i] == flt_reg[i]) begin
        cnt_next[i] = '0;
      end else if (cnt_reg[i] > {1'b0, filtMs_reg[i]} || filtMs_reg[i] == 16'h0) begin
        flt_next[i] = sync2_reg[i];
        cnt_next[i] = '0;
      end else if (msTick_reg) begin
        cnt_next[i] = cnt_reg[i] + 17'h1;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        cnt_reg[i]    <= '0;
        flt_reg[i]    <= 1'b0;
        filtMs_reg[i] <= `ICDPI_FILT_RST;
      end else begin
        cnt_reg[i]    <= cnt_next[i];
        flt_reg[i]    <= flt_next[i];
        filtMs_reg[i] <= filtMs_next[i];
      end
    end
  end

  assign logicLvl = flt_reg ^ inv_reg;

  // pairing on the logical levels
  for (genvar p = 0; p < NP; p++) begin : g_pair
    logic loAct, hiAct;
    assign loAct = swap_reg[p] ? logicLvl[2*p+1] : logicLvl[2*p];
    assign hiAct = swap_reg[p] ? logicLvl[2*p]   : logicLvl[2*p+1];
    assign dpair[2*p+1:2*p] = group_reg[p] ? {hiAct, loAct} : DP_INDET;
  end

  // configuration writes; out-of-range values leave the setting alone
  always_comb begin
    group_next = group_reg;
    swap_next  = swap_reg;
    inv_next   = inv_reg;
    mask_next  = mask_reg;
    link_next  = link_reg;
    rejectEv   = 1'b0;
    if (regWrEn) begin
      if (regAddr == `ICDPI_OFF_GROUP) begin
        for (int k = 0; k < NP; k++) begin
          group_next[k] = regWrData[2*k];
        end
        for (int k = 0; k < NP; k++) begin
          if (regWrData[2*k+1]) begin
            group_next = group_reg;
            rejectEv   = 1'b1;
          end
        end
      end else if (regAddr == `ICDPI_OFF_SWAP) begin
        swap_next = regWrData[NP-1:0];
      end else if (regAddr == `ICDPI_OFF_INVERT) begin
        inv_next = regWrData[N_IN-1:0];
      end else if (regAddr == `ICDPI_OFF_IRQ_MASK) begin
        mask_next = regWrData[2:0];
      end else if (regAddr == `ICDPI_OFF_LINK_CFG) begin
        if (regWrData[`ICDPI_F_BAUD] <= `ICDPI_BAUD_MAX) begin
          link_next.baud = icdpi_baud_e'(regWrData[`ICDPI_F_BAUD]);
        end
        if (regWrData[`ICDPI_F_PARITY] <= `ICDPI_PARITY_MAX) begin
          link_next.parity = icdpi_parity_e'(regWrData[`ICDPI_F_PARITY]);
        end
        link_next.twoStop = regWrData[`ICDPI_F_STOP2];
        if (regWrData[`ICDPI_F_ADDR] >= `ICDPI_ADDR_MIN
            && regWrData[`ICDPI_F_ADDR] <= `ICDPI_ADDR_MAX) begin
          link_next.linkAddr = regWrData[`ICDPI_F_ADDR];
        end
      end else if (regAddr == `ICDPI_OFF_LINK_TIME) begin
        if (regWrData[`ICDPI_F_BITWAIT] >= `ICDPI_BITWAIT_MIN
            && regWrData[`ICDPI_F_BITWAIT] <= `ICDPI_BITWAIT_MAX) begin
          link_next.bitWait = regWrData[`ICDPI_F_BITWAIT];
        end
        if (regWrData[`ICDPI_F_SYNC] >= `ICDPI_SYNC_MIN) begin
          link_next.syncTimeoutS = regWrData[`ICDPI_F_SYNC];
        end
      end else if (regAddr == `ICDPI_OFF_FUNC) begin
        link_next.funcType = regWrData[`ICDPI_F_FUNC];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      group_reg <= '0;
      swap_reg  <= '0;
      inv_reg   <= '0;
      mask_reg  <= '0;
      link_reg.baud     <= BAUD_19200;
      link_reg.parity   <= PAR_EVEN;
      link_reg.twoStop  <= 1'b0;
      link_reg.linkAddr <= `ICDPI_ADDR_RST;
      link_reg.bitWait      <= `ICDPI_BITWAIT_RST;
      link_reg.syncTimeoutS <= `ICDPI_SYNC_RST;
      link_reg.funcType     <= `ICDPI_FUNC_RST;
    end else begin
      group_reg <= group_next;
      swap_reg  <= swap_next;
      inv_reg   <= inv_next;
      mask_reg  <= mask_next;
      link_reg  <= link_next;
    end
  end

  // per-input request; the upper input of a pair no longer exists
  always_comb begin
    qry_next = '0;
    qErrEv   = 1'b0;
    if (qryReq) begin
      qry_next.ack = 1'b1;
      if (qryIdx[0] && group_reg[qryIdx[3:1]]) begin
        qry_next.err = 1'b1;
        qErrEv       = 1'b1;
      end else if (group_reg[qryIdx[3:1]]) begin
        qry_next.value = dpair[{qryIdx[3:1], 1'b1} -: 2];
      end else begin
        qry_next.value = {1'b0, logicLvl[qryIdx]};
      end
    end
  end

  // sticky status: a new event beats a write-one-to-clear in the same cycle
  always_comb begin
    stat_next = stat_reg;
    if (regWrEn && regAddr == `ICDPI_OFF_IRQ_STAT) begin
      stat_next = stat_reg & ~regWrData[2:0];
    end
    stat_next[`ICDPI_IRQ_CHANGE] = stat_next[`ICDPI_IRQ_CHANGE] | (flt_next != flt_reg);
    stat_next[`ICDPI_IRQ_REJECT] = stat_next[`ICDPI_IRQ_REJECT] | rejectEv;
    stat_next[`ICDPI_IRQ_QERR]   = stat_next[`ICDPI_IRQ_QERR] | qErrEv;
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    rd_next = '0;
    if (regRdEn) begin
      if (regAddr == `ICDPI_OFF_GROUP) begin
        for (int k = 0; k < NP; k++) begin
          rd_next[2*k] = group_reg[k];
        end
      end else if (regAddr == `ICDPI_OFF_SWAP) begin
        rd_next[NP-1:0] = swap_reg;
      end else if (regAddr == `ICDPI_OFF_INVERT) begin
        rd_next[N_IN-1:0] = inv_reg;
      end else if (regAddr == `ICDPI_OFF_STATE) begin
        rd_next[N_IN-1:0] = logicLvl;
      end else if (regAddr == `ICDPI_OFF_DPAIR) begin
        rd_next[N_IN-1:0] = dpair;
      end else if (regAddr == `ICDPI_OFF_IRQ_STAT) begin
        rd_next[2:0] = stat_reg;
      end else if (regAddr == `ICDPI_OFF_IRQ_MASK) begin
        rd_next[2:0] = mask_reg;
      end else if (regAddr == `ICDPI_OFF_LINK_CFG) begin
        rd_next[`ICDPI_F_BAUD]   = link_reg.baud;
        rd_next[`ICDPI_F_PARITY] = link_reg.parity;
        rd_next[`ICDPI_F_STOP2]  = link_reg.twoStop;
        rd_next[`ICDPI_F_ADDR]   = link_reg.linkAddr;
      end else if (regAddr == `ICDPI_OFF_LINK_TIME) begin
        rd_next[`ICDPI_F_BITWAIT] = link_reg.bitWait;
        rd_next[`ICDPI_F_SYNC]    = link_reg.syncTimeoutS;
      end else if (regAddr == `ICDPI_OFF_FUNC) begin
        rd_next[`ICDPI_F_FUNC] = link_reg.funcType;
      end else if (regAddr[7:6] == `ICDPI_FILT_PAGE && regAddr[1:0] == 2'h0) begin
        rd_next[15:0] = filtMs_reg[regAddr[5:2]];
      end
    end
  end

  // output flops, so every port comes straight from a register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_reg  <= '0;
      rd_reg    <= '0;
      qry_reg   <= '0;
      led_reg   <= '0;
      state_reg <= '0;
      dpair_reg <= '0;
      irq_reg   <= 1'b0;
    end else begin
      stat_reg  <= stat_next;
      rd_reg    <= rd_next;
      qry_reg   <= qry_next;
      led_reg   <= sync2_reg;
      state_reg <= logicLvl;
      dpair_reg <= dpair;
      irq_reg   <= |(stat_next & mask_next);
    end
  end

  assign regRdData = rd_reg;
  assign qryRsp    = qry_reg;
  assign ledOut    = led_reg;
  assign stateOut  = state_reg;
  assign dpairOut  = dpair_reg;
  assign linkCfg   = link_reg;
  assign irq       = irq_reg;

  // checks of the conditioning behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_upperQuery;
    qryReq && qryIdx[0] && group_reg[qryIdx[3:1]];
  endsequence

  sequence s_errAnswer;
    qryRsp.ack && qryRsp.err;
  endsequence

  a_even_reject: assert property (regWrEn && regAddr == `ICDPI_OFF_GROUP && regWrData[1]
    |=> group_reg == $past(group_reg)) else $error("even-start pairing was accepted");
  a_upper_err: assert property (s_upperQuery |=> s_errAnswer)
    else $error("upper pair input answered without error");
  a_dp_code: assert property (group_reg[0] && !swap_reg[0] && logicLvl[1:0] == 2'h1
    |=> dpairOut[1:0] == DP_OFF) else $error("lower input alone not reported as off");
  a_dp_both: assert property (group_reg[0] && logicLvl[1:0] == 2'h3
    |=> dpairOut[1:0] == DP_ERROR) else $error("both active not reported as error");
  a_dp_swap: assert property (group_reg[0] && swap_reg[0] && logicLvl[1:0] == 2'h1
    |=> dpairOut[1:0] == DP_ON) else $error("swap did not exchange roles");
  a_invert_state: assert property (##1 stateOut == $past(flt_reg ^ inv_reg))
    else $error("inverted state wrong");
  a_led_phys: assert property (##1 ledOut == $past(sync2_reg))
    else $error("indicator follows inversion");
  a_filter_wait: assert property ($changed(flt_reg[0])
    |-> $past(cnt_reg[0] > {1'b0, filtMs_reg[0]} || filtMs_reg[0] == 16'h0)
    && flt_reg[0] == $past(sync2_reg[0]))
    else $error("change accepted before filter time");
  a_reset_dflt: assert property (disable iff (1'b0) !rst_b
    |=> filtMs_reg[0] == `ICDPI_FILT_RST && linkCfg.baud == BAUD_19200
    && linkCfg.parity == PAR_EVEN) else $error("reset defaults wrong");
  a_addr_range: assert property (##1 linkCfg.linkAddr >= `ICDPI_ADDR_MIN
    && linkCfg.linkAddr <= `ICDPI_ADDR_MAX) else $error("link address out of range");

endmodule

// ### hdl/icdpi_params.svh
// offsets, field positions, reset values and timing counts of the input conditioner
`ifndef ICDPI_PARAMS_SVH
`define ICDPI_PARAMS_SVH

// register byte offsets
`define ICDPI_OFF_GROUP     8'h00
`define ICDPI_OFF_SWAP      8'h04
`define ICDPI_OFF_INVERT    8'h08
`define ICDPI_OFF_STATE     8'h0c
`define ICDPI_OFF_DPAIR     8'h10
`define ICDPI_OFF_IRQ_STAT  8'h14
`define ICDPI_OFF_IRQ_MASK  8'h18
`define ICDPI_OFF_LINK_CFG  8'h1c
`define ICDPI_OFF_LINK_TIME 8'h20
`define ICDPI_OFF_FUNC      8'h24
`define ICDPI_FILT_PAGE     2'h1

// link configuration fields
`define ICDPI_F_BAUD        3:0
`define ICDPI_F_PARITY      6:4
`define ICDPI_F_STOP2       7
`define ICDPI_F_ADDR        16:8
`define ICDPI_F_BITWAIT     8:0
`define ICDPI_F_SYNC        31:16
`define ICDPI_F_FUNC        7:0

// interrupt status bits
`define ICDPI_IRQ_CHANGE    0
`define ICDPI_IRQ_REJECT    1
`define ICDPI_IRQ_QERR      2

// reset values and limits
`define ICDPI_FILT_RST      16'h0032
`define ICDPI_BAUD_MAX      4'ha
`define ICDPI_PARITY_MAX    3'h4
`define ICDPI_ADDR_RST      9'h001
`define ICDPI_ADDR_MIN      9'h001
`define ICDPI_ADDR_MAX      9'h100
`define ICDPI_BITWAIT_RST   9'h008
`define ICDPI_BITWAIT_MIN   9'h008
`define ICDPI_BITWAIT_MAX   9'h100
`define ICDPI_SYNC_RST      16'h012c
`define ICDPI_SYNC_MIN      16'h0001
`define ICDPI_FUNC_RST      8'hfd

// timebase: one millisecond at the system clock rate
`define ICDPI_TICK_MS       1
`define ICDPI_CLK_KHZ       250000
`define ICDPI_MS_CYCLES     (`ICDPI_TICK_MS * `ICDPI_CLK_KHZ)

`endif

// ### hdl/icdpi_pkg.sv
// types shared by the input conditioner and its users
package icdpi_pkg;

  typedef enum logic [3:0] {
    BAUD_600    = 4'h0,
    BAUD_1200   = 4'h1,
    BAUD_2400   = 4'h2,
    BAUD_4800   = 4'h3,
    BAUD_9600   = 4'h4,
    BAUD_19200  = 4'h5,
    BAUD_28800  = 4'h6,
    BAUD_38400  = 4'h7,
    BAUD_57600  = 4'h8,
    BAUD_76800  = 4'h9,
    BAUD_115200 = 4'ha
  } icdpi_baud_e;

  typedef enum logic [2:0] {
    PAR_NONE  = 3'h0,
    PAR_ODD   = 3'h1,
    PAR_EVEN  = 3'h2,
    PAR_MARK  = 3'h3,
    PAR_SPACE = 3'h4
  } icdpi_parity_e;

  typedef enum logic [1:0] {
    DP_INDET = 2'h0,
    DP_OFF   = 2'h1,
    DP_ON    = 2'h2,
    DP_ERROR = 2'h3
  } icdpi_dp_e;

  typedef struct packed {
    icdpi_baud_e   baud;
    icdpi_parity_e parity;
    logic          twoStop;
    logic [8:0]    linkAddr;
    logic [8:0]    bitWait;
    logic [15:0]   syncTimeoutS;
    logic [7:0]    funcType;
  } icdpi_link_s;

  typedef struct packed {
    logic       ack;
    logic       err;
    logic [1:0] value;
  } icdpi_qry_s;

endpackage

// ### verification/icdpi_master_model.sv
// station-side model that issues per-input requests and takes the answers
module icdpi_master_model
  import icdpi_pkg::*;
(
  // clock
  input  wire logic        clk,
  // request side
  output logic             qryReq,
  output logic [3:0]       qryIdx,
  // answer side
  input  wire icdpi_qry_s  qryRsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle until the bench asks for something
  initial begin
    qryReq = 1'b0;
    qryIdx = 4'h0;
  end

  // one request; the answer stands only in the following cycle
  task automatic ask(input logic [3:0] idx, output icdpi_qry_s rsp);
    @(posedge clk);
    qryReq <= 1'b1;
    qryIdx <= idx;
    @(posedge clk);
    qryReq <= 1'b0;
    qryIdx <= ~idx;  // scrambled so a stale index is never trusted
    #1 rsp = qryRsp;
  endtask
endmodule

// ### verification/icdpi_input_cond_tb.sv
// self-checking bench for the input conditioner
`include "icdpi_params.svh"
module icdpi_input_cond_tb;
  import icdpi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // short millisecond so filter times stay affordable
  localparam int MS = 10;

  logic        clk;
  logic        rst_b;
  logic [15:0] rawIn;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [31:0] regRdData;
  logic        qryReq;
  logic [3:0]  qryIdx;
  icdpi_qry_s  qryRsp;
  logic [15:0] ledOut;
  logic [15:0] stateOut;
  logic [15:0] dpairOut;
  icdpi_link_s linkCfg;
  logic        irq;
  int          n_mismatch;
  int          checks;

  icdpi_input_cond #(.MS_CYCLES(MS), .N_IN(16)) dut (
    .clk(clk), .rst_b(rst_b), .rawIn(rawIn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .qryReq(qryReq), .qryIdx(qryIdx), .qryRsp(qryRsp),
    .ledOut(ledOut), .stateOut(stateOut), .dpairOut(dpairOut),
    .linkCfg(linkCfg), .irq(irq)
  );

  icdpi_master_model mst (.clk(clk), .qryReq(qryReq), .qryIdx(qryIdx), .qryRsp(qryRsp));

  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // single comparison point
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // write; effect visible after the following edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn   <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // read; data stands one cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic drive(input logic [15:0] v);
    @(posedge clk);
    rawIn <= v;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // reset values of link settings and of the input 5 filter time
  task automatic test_reset();
    icdpi_link_s e;
    logic [31:0] d;
    e = '{BAUD_19200, PAR_EVEN, 1'b0, 9'h001, 9'h008, 16'h012c, 8'hfd};
    chk("linkCfg", linkCfg, e);
    rd(8'h54, d);
    chk("filter5", d, 32'h32);
    rd(8'h3c, d);
    chk("unmapped", d, 32'h0);
    chk("irq", irq, 1'b0);
    $display("test_reset done");
  endtask

  // every baud and parity code, then refused values
  task automatic test_link();
    icdpi_link_s e;
    e = linkCfg;
    for (int i = 0; i < 11; i++) begin
      wr(`ICDPI_OFF_LINK_CFG, {15'h0, 9'h001, 1'b0, 3'(i % 5), 4'(i)});
      e.baud   = icdpi_baud_e'(4'(i));
      e.parity = icdpi_parity_e'(3'(i % 5));
      chk("baud", linkCfg, e);
    end
    wr(`ICDPI_OFF_LINK_CFG, {15'h0, 9'h000, 1'b1, 3'h5, 4'hb});
    e.twoStop = 1'b1;
    chk("refused", linkCfg, e);
    wr(`ICDPI_OFF_LINK_CFG, {15'h0, 9'h100, 1'b0, 3'h4, 4'h5});
    e = '{BAUD_19200, PAR_SPACE, 1'b0, 9'h100, e.bitWait, e.syncTimeoutS, e.funcType};
    chk("addr256", linkCfg, e);
    wr(`ICDPI_OFF_LINK_TIME, {16'h0000, 7'h0, 9'h007});
    chk("timeRef", linkCfg, e);
    wr(`ICDPI_OFF_LINK_TIME, {16'hffff, 7'h0, 9'h100});
    wr(`ICDPI_OFF_FUNC, 32'h2a);
    e.bitWait      = 9'h100;
    e.syncTimeoutS = 16'hffff;
    e.funcType     = 8'h2a;
    chk("timeMax", linkCfg, e);
    $display("test_link done");
  endtask

  // debounce with restart on a bounce, own and default times, interrupt
  task automatic test_filter();
    wr(8'h50, 32'h3);
    drive(16'h0030);
    tick(4);
    chk("led", ledOut, 16'h0030);
    chk("early", stateOut, 16'h0);
    tick(16);
    drive(16'h0020);
    tick(2);
    drive(16'h0030);
    tick(25);
    chk("restart", stateOut, 16'h0);
    tick(25);
    chk("accept", stateOut, 16'h0010);
    chk("masked", irq, 1'b0);
    wr(`ICDPI_OFF_IRQ_MASK, 32'h1);
    chk("irqOn", irq, 1'b1);
    wr(`ICDPI_OFF_IRQ_STAT, 32'h1);
    chk("irqClr", irq, 1'b0);
    tick(420);
    chk("dflt50", stateOut, 16'h0010);
    tick(30);
    chk("dflt50b", stateOut, 16'h0030);
    wr(`ICDPI_OFF_IRQ_STAT, 32'h7);
    wr(`ICDPI_OFF_IRQ_MASK, 32'h0);
    $display("test_filter done");
  endtask

  // inversion chosen per input, indicators untouched
  task automatic test_invert();
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h0);
    wr(`ICDPI_OFF_INVERT, 32'h2);
    drive(16'h0033);
    tick(8);
    chk("invAct", stateOut, 16'h0031);
    chk("ledAct", ledOut, 16'h0033);
    drive(16'h0030);
    tick(8);
    chk("invIdle", stateOut, 16'h0032);
    wr(`ICDPI_OFF_INVERT, 32'h0);
    tick(8);
    $display("test_invert done");
  endtask

  // grouping, refusal, all four pair values, swap, queries
  task automatic test_pair();
    logic [31:0] d;
    icdpi_qry_s  r;
    logic [1:0]  ev;
    wr(`ICDPI_OFF_IRQ_STAT, 32'h7);
    wr(`ICDPI_OFF_GROUP, 32'h2);
    rd(`ICDPI_OFF_GROUP, d);
    chk("evenStart", d, 32'h0);
    rd(`ICDPI_OFF_IRQ_STAT, d);
    chk("rejStat", d, 32'h2);
    wr(`ICDPI_OFF_GROUP, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr(`ICDPI_OFF_SWAP, 32'(s));
      for (int v = 0; v < 4; v++) begin
        drive({14'h000c, 2'(v)});
        tick(8);
        ev = (s == 1) ? {v[0], v[1]} : 2'(v);
        chk("dpair", dpairOut, {14'h0, ev});
        mst.ask(4'h0, r);
        chk("qryPair", r, {2'b10, ev});
      end
    end
    mst.ask(4'h1, r);
    chk("qryUpper", r, 4'hc);
    mst.ask(4'h4, r);
    chk("qrySingle", r, 4'h9);
    rd(`ICDPI_OFF_IRQ_STAT, d);
    chk("qErrStat", d[2], 1'b1);
    $display("test_pair done");
  endtask

  // main sequence
  initial begin
    n_mismatch = 0;
    checks     = 0;
    rst_b      = 1'b0;
    rawIn      = 16'h0;
    regAddr    = 8'h0;
    regWrData  = 32'h0;
    regWrEn    = 1'b0;
    regRdEn    = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    test_reset();
    test_link();
    test_filter();
    test_invert();
    test_pair();
    report_and_stop();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
